/* ssp_pkg.sv */
// shared constants, register map and state type of the synchronous slave serial port
package ssp_pkg;
    // register indexes on the plain register port
    localparam logic [3:0] ADDR_INT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PERI_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_PERI_ENABLES = 4'h2;
    localparam logic [3:0] ADDR_PERI_PRIORITY = 4'h3;
    localparam logic [3:0] ADDR_RX_STATUS = 4'h4;
    localparam logic [3:0] ADDR_TX_HOLD = 4'h5;
    localparam logic [3:0] ADDR_TX_STATUS = 4'h6;
    localparam logic [3:0] ADDR_BAUD_CTRL = 4'h7;
    localparam logic [3:0] ADDR_BAUD_DIV_HI = 4'h8;
    localparam logic [3:0] ADDR_BAUD_DIV_LO = 4'h9;
    localparam logic [3:0] ADDR_RX_HOLD = 4'ha;

    // field positions
    localparam int BIT_GIE = 7;
    localparam int BIT_PERIPHERAL_INT_ENABLE = 6;
    localparam int BIT_RCIF = 5;
    localparam int BIT_TXIF = 4;
    localparam int BIT_SERIAL_PORT_ENABLE = 7;
    localparam int BIT_RX9 = 6;
    localparam int BIT_SINGLE_RX_ENABLE = 5;
    localparam int BIT_CONTINUOUS_RX_ENABLE = 4;
    localparam int BIT_FRAME_ERROR_FLAG = 2;
    localparam int BIT_OVERRUN_ERROR_FLAG = 1;
    localparam int BIT_RX_NINTH_BIT = 0;
    localparam int BIT_CLOCK_SOURCE_SELECT = 7;
    localparam int BIT_TX9 = 6;
    localparam int BIT_TRANSMIT_ENABLE_BIT = 5;
    localparam int BIT_SYNC = 4;
    localparam int BIT_TX_SHIFT_EMPTY = 1;
    localparam int BIT_TX_NINTH_BIT = 0;

    // word lengths in shift clocks
    localparam logic [3:0] WORD_BITS_8 = 4'h8;
    localparam logic [3:0] WORD_BITS_9 = 4'h9;

    typedef struct packed {
        logic global_int_enable;
        logic peripheral_int_enable;
        logic rcie;
        logic txie;
        logic [7:0] prio;
        logic serial_port_enable;
        logic rx9;
        logic single_rx_enable;
        logic continuous_rx_enable;
        logic overrun_error_flag;
        logic rx_ninth_bit;
        logic clock_source_select;
        logic tx9;
        logic transmit_enable_bit;
        logic sync;
        logic tx_ninth_bit;
        logic [7:0] baud_ctl;
        logic [7:0] div_hi;
        logic [7:0] div_lo;
        logic [7:0] hold;
        logic hold9;
        logic hold_full;
        logic txif;
        logic txif_pend;
        logic [8:0] tx_shift_reg;
        logic tsr_full;
        logic [3:0] tx_cnt;
        logic tx_out;
        logic [8:0] rx_shift_reg;
        logic [3:0] rx_cnt;
        logic [7:0] rx_hold;
        logic rcif;
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic dt_s1;
        logic dt_s2;
        logic [7:0] rdata;
    } ssp_state_t;

    // holding register starts empty, so its empty flag starts set
    localparam ssp_state_t SSP_STATE_RST = '{txif: 1'b1, default: '0};
endpackage

/* ssp_sync_slave.sv */
// synchronous slave half-duplex serial port with register port
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RQ1 - slave transmit works like master transmit, also during sleep
// RQ2 - with two words queued, the first moves into the shift register at once
// RQ3 - second word waits in holding; empty flag stays clear meanwhile
// RQ4 - after first word finishes, second word loads, then empty flag sets
// RQ5 - empty flag with its enable raises wake; vectoring needs global enable
// RQ6 - slave when sync mode=1, port enable=1, clock source select=0
// RQ7 - transmit needs both receive enables clear
// RQ8 - nine-bit select sends 9 bits, ninth from tx ninth-bit field
// RQ9 - with transmit enabled, holding write starts a word on external clock
// RQ10 - single receive enable has no effect on slave reception
// RQ11 - continuous receive keeps working in any low-power mode
// RQ12 - finished word moves to rx holding; enabled interrupt wakes device
// RQ13 - receive-complete flag sets per word; interrupt only when enabled
// RQ14 - nine-bit receive; ninth bit and errors read in rx status
// RQ15 - software reads rx status before rx holding
// RQ16 - clearing continuous receive clears receive errors
// RQ17 - software sets global and peripheral enables, bits 7 and 6
// RQ18 - external master supplies shift clock; device never drives it
// RQ19 - empty flag sets one cycle after load; only a holding write clears
// RQ20 - shift-empty status reads 1 whenever transmit shift register empty
// RQ21 - port disabled: shift clock ignored, shift logic held idle
module ssp_sync_slave
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic shift_clock_pin,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    output logic wake_req,
    output logic int_req
);

    ssp_state_t st_q;
    ssp_state_t st_d;
    logic slave_on;
    logic tx_on;
    logic rx_on;
    logic ck_rise;
    logic ck_fall;
    logic hold_wr;
    logic hold_rd;
    logic load_tx;
    logic tx_last;
    logic rx_done;
    logic [8:0] rx_new;

    function automatic logic [3:0] word_bits(input logic nine);
        word_bits = nine ? WORD_BITS_9 : WORD_BITS_8;
    endfunction

    function automatic logic [7:0] read_reg(input ssp_state_t s, input logic [3:0] a);
        read_reg = 8'h00;
        case (a)
            ADDR_INT_CTRL: begin
                read_reg[BIT_GIE] = s.global_int_enable;
                read_reg[BIT_PERIPHERAL_INT_ENABLE] = s.peripheral_int_enable;
            end
            ADDR_PERI_FLAGS: begin
                read_reg[BIT_RCIF] = s.rcif;
                read_reg[BIT_TXIF] = s.txif;
            end
            ADDR_PERI_ENABLES: begin
                read_reg[BIT_RCIF] = s.rcie;
                read_reg[BIT_TXIF] = s.txie;
            end
            ADDR_PERI_PRIORITY: read_reg = s.prio;
            ADDR_RX_STATUS: begin
                read_reg[BIT_SERIAL_PORT_ENABLE] = s.serial_port_enable;
                read_reg[BIT_RX9] = s.rx9;
                read_reg[BIT_SINGLE_RX_ENABLE] = s.single_rx_enable;
                read_reg[BIT_CONTINUOUS_RX_ENABLE] = s.continuous_rx_enable;
                read_reg[BIT_FRAME_ERROR_FLAG] = 1'b0;
                read_reg[BIT_OVERRUN_ERROR_FLAG] = s.overrun_error_flag; // RQ14
                read_reg[BIT_RX_NINTH_BIT] = s.rx_ninth_bit; // RQ14
            end
            ADDR_TX_STATUS: begin
                read_reg[BIT_CLOCK_SOURCE_SELECT] = s.clock_source_select;
                read_reg[BIT_TX9] = s.tx9;
                read_reg[BIT_TRANSMIT_ENABLE_BIT] = s.transmit_enable_bit;
                read_reg[BIT_SYNC] = s.sync;
                read_reg[BIT_TX_SHIFT_EMPTY] = !s.tsr_full; // RQ20
                read_reg[BIT_TX_NINTH_BIT] = s.tx_ninth_bit;
            end
            ADDR_BAUD_CTRL: read_reg = s.baud_ctl;
            ADDR_BAUD_DIV_HI: read_reg = s.div_hi;
            ADDR_BAUD_DIV_LO: read_reg = s.div_lo;
            ADDR_RX_HOLD: read_reg = s.rx_hold;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // master-mode clocking is not built; with clock source select set the port idles
    assign slave_on = st_q.sync && st_q.serial_port_enable && !st_q.clock_source_select; // RQ6 RQ21
    assign tx_on = slave_on && st_q.transmit_enable_bit && !st_q.continuous_rx_enable && !st_q.single_rx_enable; // RQ7
    assign rx_on = slave_on && st_q.continuous_rx_enable; // RQ10 RQ11
    // edges come from the second and third stages, never the first
    assign ck_rise = st_q.ck_s2 && !st_q.ck_s3;
    assign ck_fall = !st_q.ck_s2 && st_q.ck_s3;
    assign hold_wr = reg_wr && (reg_addr == ADDR_TX_HOLD);
    assign hold_rd = reg_rd && (reg_addr == ADDR_RX_HOLD);
    assign load_tx = tx_on && st_q.hold_full && !st_q.tsr_full; // RQ2 RQ4
    assign tx_last = tx_on && st_q.tsr_full && ck_fall
        && (st_q.tx_cnt == word_bits(st_q.tx9));
    assign rx_new = {st_q.dt_s2, st_q.rx_shift_reg[8:1]};
    assign rx_done = rx_on && ck_fall && ((st_q.rx_cnt + 4'h1) == word_bits(st_q.rx9));

    always_comb begin
        st_d = st_q;
        st_d.ck_s1 = shift_clock_pin; // RQ18
        st_d.ck_s2 = st_q.ck_s1;
        st_d.ck_s3 = st_q.ck_s2;
        st_d.dt_s1 = data_pin_in;
        st_d.dt_s2 = st_q.dt_s1;
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            st_d.rdata = read_reg(st_q, reg_addr);
        end
        // writes to the flag register are dropped: neither flag can be cleared by writing it
        if (reg_wr) begin
            case (reg_addr)
                ADDR_INT_CTRL: begin
                    st_d.global_int_enable = reg_wdata[BIT_GIE];
                    st_d.peripheral_int_enable = reg_wdata[BIT_PERIPHERAL_INT_ENABLE];
                end
                ADDR_PERI_ENABLES: begin
                    st_d.rcie = reg_wdata[BIT_RCIF];
                    st_d.txie = reg_wdata[BIT_TXIF];
                end
                ADDR_PERI_PRIORITY: st_d.prio = reg_wdata;
                ADDR_RX_STATUS: begin
                    st_d.serial_port_enable = reg_wdata[BIT_SERIAL_PORT_ENABLE];
                    st_d.rx9 = reg_wdata[BIT_RX9];
                    st_d.single_rx_enable = reg_wdata[BIT_SINGLE_RX_ENABLE];
                    st_d.continuous_rx_enable = reg_wdata[BIT_CONTINUOUS_RX_ENABLE];
                end
                ADDR_TX_STATUS: begin
                    st_d.clock_source_select = reg_wdata[BIT_CLOCK_SOURCE_SELECT];
                    st_d.tx9 = reg_wdata[BIT_TX9];
                    st_d.transmit_enable_bit = reg_wdata[BIT_TRANSMIT_ENABLE_BIT];
                    st_d.sync = reg_wdata[BIT_SYNC];
                    st_d.tx_ninth_bit = reg_wdata[BIT_TX_NINTH_BIT];
                end
                ADDR_BAUD_CTRL: st_d.baud_ctl = reg_wdata;
                ADDR_BAUD_DIV_HI: st_d.div_hi = reg_wdata;
                ADDR_BAUD_DIV_LO: st_d.div_lo = reg_wdata;
                default: ;
            endcase
        end

        // transmit: load before the holding write so a same-cycle write is kept
        st_d.txif_pend = load_tx;
        if (st_q.txif_pend) begin
            st_d.txif = 1'b1; // RQ19 RQ4
        end
        if (load_tx) begin
            st_d.tx_shift_reg = {st_q.hold9, st_q.hold}; // RQ8
            st_d.tsr_full = 1'b1;
            st_d.tx_cnt = 4'h0;
            st_d.hold_full = 1'b0;
        end else if (tx_on && st_q.tsr_full && ck_rise
                     && (st_q.tx_cnt < word_bits(st_q.tx9))) begin
            st_d.tx_out = st_q.tx_shift_reg[0]; // RQ9 RQ1
            st_d.tx_shift_reg = {1'b0, st_q.tx_shift_reg[8:1]};
            st_d.tx_cnt = st_q.tx_cnt + 4'h1;
        end else if (tx_last) begin
            st_d.tsr_full = 1'b0;
        end
        if (hold_wr) begin
            st_d.hold = reg_wdata; // RQ3
            st_d.hold9 = st_q.tx_ninth_bit; // RQ8
            st_d.hold_full = 1'b1;
            // refilled holding cannot read empty, so the write wins here
            st_d.txif = 1'b0; // RQ19
        end
        if (!tx_on) begin
            st_d.tsr_full = 1'b0; // RQ21
            st_d.tx_cnt = 4'h0;
            st_d.tx_out = 1'b0;
        end

        // receive: read-clear first so a completing word's set wins
        if (hold_rd) begin
            st_d.rcif = 1'b0;
        end
        if (rx_on && ck_fall) begin
            st_d.rx_shift_reg = rx_new;
            st_d.rx_cnt = st_q.rx_cnt + 4'h1;
            if (rx_done) begin
                st_d.rx_cnt = 4'h0;
                if (st_d.rcif) begin
                    // unread word is kept; the new one is lost
                    st_d.overrun_error_flag = 1'b1;
                end else begin
                    st_d.rx_hold = st_q.rx9 ? rx_new[7:0] : rx_new[8:1]; // RQ12
                    st_d.rx_ninth_bit = st_q.rx9 ? rx_new[8] : 1'b0; // RQ14
                    st_d.rcif = 1'b1; // RQ13
                end
            end
        end
        if (!rx_on) begin
            st_d.rx_cnt = 4'h0; // RQ21
        end
        if (!st_d.continuous_rx_enable) begin
            st_d.overrun_error_flag = 1'b0; // RQ16
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SSP_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign data_pin_out = st_q.tx_out;
    assign data_pin_oe = tx_on;
    // wake ignores the global enables; vectoring does not
    assign wake_req = (st_q.txif && st_q.txie) || (st_q.rcif && st_q.rcie); // RQ5 RQ12
    assign int_req = wake_req && st_q.global_int_enable && st_q.peripheral_int_enable; // RQ5 RQ17

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_load_no_write;
        load_tx ##1 !hold_wr;
    endsequence

    chk_txif_after_load: assert property (s_load_no_write |=> st_q.txif) // RQ19
        else $error("empty flag not set one cycle after load");
    chk_txif_write_clear: assert property (hold_wr |=> !st_q.txif && st_q.hold_full) // RQ19
        else $error("holding write did not clear empty flag");
    chk_second_word_wait: assert property (st_q.tsr_full && st_q.hold_full |-> !st_q.txif) // RQ3
        else $error("empty flag set while second word waits");
    chk_tx_shift_empty_reads_shift: assert property ( // RQ20
        reg_rd && reg_addr == ADDR_TX_STATUS |=> reg_rdata[BIT_TX_SHIFT_EMPTY] == !$past(st_q.tsr_full))
        else $error("shift-empty bit wrong");
    // the flag of a reload comes two cycles after the emptying, so only the emptying is timed here
    chk_tx_word_end: assert property (tx_last |=> !st_q.tsr_full) // RQ8
        else $error("shift register not emptied after last bit");
    chk_idle_disabled: assert property (!slave_on |=> !st_q.tsr_full && st_q.rx_cnt == 4'h0) // RQ21
        else $error("shift logic active while port disabled");
    chk_rx_flag_set: assert property (rx_done && !st_q.rcif |=> st_q.rcif) // RQ13
        else $error("receive-complete flag missed");
    chk_overrun_error_flag_cleared: assert property ($fell(st_q.continuous_rx_enable) |-> !st_q.overrun_error_flag) // RQ16
        else $error("overrun kept after receive disabled");
    chk_half_duplex: assert property (st_q.continuous_rx_enable || st_q.single_rx_enable |-> !data_pin_oe ##1 !st_q.tsr_full) // RQ7
        else $error("transmit active with receive enabled");
    chk_wake_tx: assert property ( // RQ5
        st_q.txif && st_q.txie |-> wake_req && (int_req == (st_q.global_int_enable && st_q.peripheral_int_enable)))
        else $error("transmit wake or vector wrong");

    // one bit leaves per detected rising edge while the word is not yet complete
    sequence s_tx_bit_edge;
        tx_on && st_q.tsr_full && ck_rise && (st_q.tx_cnt < word_bits(st_q.tx9));
    endsequence

    // a finished word that finds the holding register already read
    sequence s_rx_free_word;
        rx_done && !st_q.rcif;
    endsequence

    chk_load_empties_hold: assert property ( // RQ2
        load_tx && !hold_wr |=> st_q.tsr_full && !st_q.hold_full)
        else $error("load did not move word into shift register");

    chk_load_takes_word: assert property ( // RQ8
        load_tx |=> st_q.tx_shift_reg == {$past(st_q.hold9), $past(st_q.hold)})
        else $error("shift register loaded with wrong word");

    // a config write in the emptying cycle may switch transmit off, so it is left out
    chk_reload_second: assert property ( // RQ4
        tx_last && st_q.hold_full && !reg_wr |=> load_tx)
        else $error("second word not reloaded after first");

    chk_bit_on_rise: assert property ( // RQ9
        s_tx_bit_edge |=> data_pin_out == $past(st_q.tx_shift_reg[0]))
        else $error("data bit not shifted on rising edge");

    chk_bit_stands: assert property ( // RQ1
        tx_on && !ck_rise && !reg_wr |=> $stable(data_pin_out))
        else $error("data bit changed between rising edges");

    chk_off_no_drive: assert property (!tx_on |=> !data_pin_out) // RQ21
        else $error("data driven with transmit off");

    chk_shift_clear_off: assert property (!tx_on |=> !st_q.tsr_full) // RQ7
        else $error("shift register kept with transmit off");

    chk_rx_idle_off: assert property (!rx_on |=> st_q.rx_cnt == 4'h0) // RQ21
        else $error("receive count moved with receiver off");

    chk_single_rx_enable_no_rx: assert property ( // RQ10
        !st_q.continuous_rx_enable && st_q.single_rx_enable |=> !$rose(st_q.rcif))
        else $error("single receive enable started reception");

    chk_rx_word_lands: assert property ( // RQ12
        s_rx_free_word |=> st_q.rx_hold
            == ($past(st_q.rx9) ? $past(rx_new[7:0]) : $past(rx_new[8:1])))
        else $error("received word not moved to holding");

    chk_rx_ninth: assert property ( // RQ14
        rx_done && !st_q.rcif && st_q.rx9 |=> st_q.rx_ninth_bit == $past(st_q.dt_s2))
        else $error("ninth received bit wrong");

    chk_rx8_ninth_zero: assert property ( // RQ14
        rx_done && !st_q.rcif && !st_q.rx9 |=> !st_q.rx_ninth_bit)
        else $error("ninth bit set in eight-bit reception");

    chk_overrun_set: assert property ( // RQ14
        rx_done && st_q.rcif && !hold_rd && !reg_wr |=> st_q.overrun_error_flag)
        else $error("overrun not flagged");

    // the unread word wins over the newcomer
    chk_overrun_keeps: assert property ( // RQ12
        rx_done && st_q.rcif && !hold_rd |=> $stable(st_q.rx_hold))
        else $error("unread word overwritten on overrun");

    chk_rcif_read_clear: assert property (hold_rd && !rx_done |=> !st_q.rcif) // RQ13
        else $error("reading holding did not clear flag");

    chk_rcif_set_wins: assert property (hold_rd && rx_done |=> st_q.rcif) // RQ13
        else $error("completing word lost to read clear");

    chk_rcif_sticky: assert property (st_q.rcif && !hold_rd |=> st_q.rcif) // RQ13
        else $error("receive flag dropped without read");

    chk_txif_sticky: assert property (st_q.txif && !hold_wr |=> st_q.txif) // RQ19
        else $error("empty flag dropped without holding write");

    chk_txif_rise_cause: assert property ($rose(st_q.txif) |-> $past(st_q.txif_pend)) // RQ19
        else $error("empty flag set without a load");

    chk_txif_hold_full: assert property (st_q.hold_full |-> !st_q.txif) // RQ3
        else $error("empty flag set with holding full");

    chk_rx_wake: assert property (st_q.rcif && st_q.rcie |-> wake_req) // RQ12
        else $error("receive wake missing");

    chk_int_needs_enables: assert property (int_req |-> st_q.global_int_enable && st_q.peripheral_int_enable) // RQ5
        else $error("vector request without global enables");

    chk_no_wake_idle: assert property ( // RQ13
        !(st_q.txif && st_q.txie) && !(st_q.rcif && st_q.rcie) |-> !wake_req)
        else $error("wake raised with no enabled flag");

    chk_continuous_rx_enable_no_overrun_error_flag: assert property (!st_q.continuous_rx_enable |-> !st_q.overrun_error_flag) // RQ16
        else $error("overrun kept with receive disabled");

endmodule
`default_nettype wire

/* ssp_master_model.sv */
// behavioural external master that clocks the slave port
`timescale 1ns/100ps
`default_nettype none
module ssp_master_model (
    output logic shift_clk,
    output logic drv_bit,
    input wire logic data_line
);
    initial begin
        shift_clk = 1'b0;
        drv_bit = 1'b0;
    end
    // clock stands low between frames; released data flips so no stale bit survives
    task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
        rx = '0;
        for (int i = 0; i < n; i++) begin
            drv_bit = tx[i];
            shift_clk = 1'b1;
            #80;
            shift_clk = 1'b0;
            #80;
            rx[i] = data_line;
        end
        drv_bit = ~drv_bit;
    endtask
endmodule
`default_nettype wire

/* tb_sync_slave_serial_port.sv */
// self-checking bench for the synchronous slave serial port
`timescale 1ns/100ps
`default_nettype none
module tb_sync_slave_serial_port;
    import ssp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic data_pin_out, data_pin_oe, wake_req, int_req, shift_clk, m_drv;
    logic data_line;
    logic [8:0] got;
    int errors = 0;
    int checks_done = 0;

    always #10 sys_clk = ~sys_clk;
    // half-duplex data wire: the slave wins while it drives
    assign data_line = data_pin_oe ? data_pin_out : m_drv;

    ssp_sync_slave DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .shift_clock_pin(shift_clk), .data_pin_in(data_line), .data_pin_out(data_pin_out),
        .data_pin_oe(data_pin_oe), .wake_req(wake_req), .int_req(int_req));
    ssp_master_model u_master (.shift_clk(shift_clk), .drv_bit(m_drv), .data_line(data_line));

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic w(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic r(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(what, {1'b0, reg_rdata}, {1'b0, exp});
    endtask

    task automatic wait_wake();
        int n;
        n = 0;
        while (wake_req !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 100) begin
            errors++;
            $display("unexpected wake_req: expected 1, seen timeout");
            give_verdict();
        end
    endtask

    task automatic test_regs();
        r("int ctrl", ADDR_INT_CTRL, 8'h00);
        r("flags", ADDR_PERI_FLAGS, 8'h10);
        r("tx status", ADDR_TX_STATUS, 8'h02);
        w(ADDR_PERI_PRIORITY, 8'h5a);
        r("priority", ADDR_PERI_PRIORITY, 8'h5a);
        w(ADDR_BAUD_DIV_LO, 8'ha5);
        r("divisor low", ADDR_BAUD_DIV_LO, 8'ha5);
        w(ADDR_PERI_FLAGS, 8'h00);
        r("flags written", ADDR_PERI_FLAGS, 8'h10);
        r("unmapped", 4'hb, 8'h00);
        r("tx holding", ADDR_TX_HOLD, 8'h00);
        #20 check("rdata after", {1'b0, reg_rdata}, 9'h000);
        $display("test regs done");
    endtask

    task automatic test_tx();
        w(ADDR_PERI_ENABLES, 8'h10);
        w(ADDR_RX_STATUS, 8'h80);
        w(ADDR_TX_STATUS, 8'h70);
        w(ADDR_TX_HOLD, 8'h5c);
        repeat (6) @(posedge sys_clk);
        w(ADDR_TX_STATUS, 8'h71);
        w(ADDR_TX_HOLD, 8'hc3);
        r("flags queued", ADDR_PERI_FLAGS, 8'h00);
        r("tx busy", ADDR_TX_STATUS, 8'h71);
        check("oe", {8'h00, data_pin_oe}, 9'h001);
        check("wake queued", {8'h00, wake_req}, 9'h000);
        u_master.xfer(9, 9'h000, got);
        check("first word", got, 9'h05c);
        wait_wake();
        check("int gated", {8'h00, int_req}, 9'h000);
        r("second loaded", ADDR_TX_STATUS, 8'h71);
        w(ADDR_INT_CTRL, 8'hc0);
        check("int on", {8'h00, int_req}, 9'h001);
        w(ADDR_INT_CTRL, 8'h00);
        u_master.xfer(9, 9'h000, got);
        check("second word", got, 9'h1c3);
        r("tx idle", ADDR_TX_STATUS, 8'h73);
        $display("test tx done");
    endtask

    task automatic test_tx_block();
        w(ADDR_RX_STATUS, 8'h90);
        check("oe cont rx", {8'h00, data_pin_oe}, 9'h000);
        w(ADDR_RX_STATUS, 8'ha0);
        check("oe single rx", {8'h00, data_pin_oe}, 9'h000);
        w(ADDR_TX_STATUS, 8'hb0);
        check("oe master", {8'h00, data_pin_oe}, 9'h000);
        $display("test tx block done");
    endtask

    task automatic test_rx();
        w(ADDR_PERI_ENABLES, 8'h20);
        w(ADDR_TX_STATUS, 8'h10);
        w(ADDR_RX_STATUS, 8'hf0);
        u_master.xfer(9, 9'h1a5, got);
        wait_wake();
        r("flags rx", ADDR_PERI_FLAGS, 8'h30);
        r("rx ninth", ADDR_RX_STATUS, 8'hf1);
        r("rx word", ADDR_RX_HOLD, 8'ha5);
        r("flags read", ADDR_PERI_FLAGS, 8'h10);
        w(ADDR_PERI_ENABLES, 8'h00);
        u_master.xfer(9, 9'h03c, got);
        repeat (8) @(posedge sys_clk);
        #1 check("wake off", {8'h00, wake_req}, 9'h000);
        r("flags no ie", ADDR_PERI_FLAGS, 8'h30);
        u_master.xfer(9, 9'h0ff, got);
        repeat (8) @(posedge sys_clk);
        r("overrun", ADDR_RX_STATUS, 8'hf2);
        r("kept word", ADDR_RX_HOLD, 8'h3c);
        w(ADDR_RX_STATUS, 8'he0);
        r("err cleared", ADDR_RX_STATUS, 8'he0);
        $display("test rx done");
    endtask

    // single receive alone, and a disabled port, must both let a word pass unseen
    task automatic test_ignored();
        logic [7:0] cfg [2] = '{8'ha0, 8'h10};
        for (int i = 0; i < 2; i++) begin
            w(ADDR_RX_STATUS, cfg[i]);
            u_master.xfer(8, 9'h066, got);
            repeat (8) @(posedge sys_clk);
            r("flags ignored", ADDR_PERI_FLAGS, 8'h10);
        end
        $display("test ignored done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_regs();
        test_tx();
        test_tx_block();
        test_rx();
        test_ignored();
        give_verdict();
    end

    initial begin
        #200000;
        errors++;
        $display("unexpected run time: expected end, seen limit");
        give_verdict();
    end
endmodule
`default_nettype wire
